// ===== hw/ramp_pkg.sv
// Package with constants and types for the frequency ramp generator.
package ramp_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the APB bus).
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF       = 8'h00;
  localparam logic [7:0] INC0_OFF       = 8'h04;
  localparam logic [7:0] INC1_OFF       = 8'h08;
  localparam logic [7:0] LEN0_OFF       = 8'h0c;
  localparam logic [7:0] LEN1_OFF       = 8'h10;
  localparam logic [7:0] THRESH_LO_OFF  = 8'h14;
  localparam logic [7:0] THRESH_HI_OFF  = 8'h18;
  localparam logic [7:0] LOW_LO_OFF     = 8'h1c;
  localparam logic [7:0] LOW_HI_OFF     = 8'h20;
  localparam logic [7:0] HIGH_LO_OFF    = 8'h24;
  localparam logic [7:0] HIGH_HI_OFF    = 8'h28;
  localparam logic [7:0] NUM_LO_OFF     = 8'h2c;
  localparam logic [7:0] NUM_HI_OFF     = 8'h30;
  localparam logic [7:0] STATUS_OFF     = 8'h34;

  // ****************************************************************
  // Control field positions.
  // ****************************************************************
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_PIN_BIT    = 1;
  localparam int CTRL_CALSEG_BIT = 2;
  localparam int CTRL_START_BIT  = 3;
  localparam int CTRL_CALDONE_BIT = 4;

  // ****************************************************************
  // Widths, reset values and timing.
  // ****************************************************************
  localparam int INC_W = 30;
  localparam int LEN_W = 16;
  localparam int NUM_W = 34;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [NUM_W-1:0] HIGH_RESET = 34'h1_ffff_ffff;
  localparam logic [NUM_W-1:0] LOW_RESET  = 34'h2_0000_0000;

  // Time a forced calibration holds off steps, in nanoseconds.
  localparam int CAL_TIME_NS   = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEG0 = 4'b0010,
    ST_SEG1 = 4'b0100,
    ST_DONE = 4'b1000
  } ramp_state_t;

endpackage

// ===== hw/strobe_if.sv
// Interface carrying the resynchronised step strobe into the core domain.
`timescale 1ns/1ns
interface strobe_if;
  logic step_pulse;
  logic step_dir;

  modport src (output step_pulse, output step_dir);
  modport dst (input step_pulse, input step_dir);
endinterface

// ===== hw/strobe_sync.sv
// Link-clock strobe catcher and toggle crossing into the system clock.
`timescale 1ns/1ns
module strobe_sync (
  input  wire logic link_clk,
  input  wire logic link_rst_b,
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic strobe_in,
  input  wire logic dir_in,
  strobe_if.src     out
);

  // ****************************************************************
  // Link side: catch rising edges and flip a toggle.
  // ****************************************************************
  logic strobe_m_reg, strobe_s_reg, strobe_d_reg, tog_reg;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      strobe_m_reg <= 1'b0;
      strobe_s_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      tog_reg      <= 1'b0;
    end else begin
      strobe_m_reg <= strobe_in;
      strobe_s_reg <= strobe_m_reg;
      strobe_d_reg <= strobe_s_reg;
      if (strobe_s_reg && !strobe_d_reg) begin
        tog_reg <= ~tog_reg;
      end
    end
  end

  // ****************************************************************
  // System side: resynchronise toggle and direction level.
  // ****************************************************************
  logic t_m_reg, t_s_reg, t_d_reg, d_m_reg, d_s_reg;

  // Direction is a slow level held apart from strobe edges by the controller.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      t_m_reg <= 1'b0;
      t_s_reg <= 1'b0;
      t_d_reg <= 1'b0;
      d_m_reg <= 1'b0;
      d_s_reg <= 1'b0;
    end else begin
      t_m_reg <= tog_reg;
      t_s_reg <= t_m_reg;
      t_d_reg <= t_s_reg;
      d_m_reg <= dir_in;
      d_s_reg <= d_m_reg;
    end
  end

  assign out.step_pulse = t_s_reg ^ t_d_reg;
  assign out.step_dir   = d_s_reg;

endmodule // strobe_sync

// ===== hw/ramp_gen.sv
// Frequency ramp generator core with APB registers.
//
// Overview of operation
// - No ramping unless ramp_active is one.
// - Pin select chooses automatic or strobe clocking.
// - Add selected increment each ramp clock.
// - Increments are thirty-bit two's complement values.
// - Segment length counts ramp clock cycles.
// - Recalibrate when numerator drifts by threshold.
// - Optionally recalibrate at every segment start.
// - Clamp numerator between low and high bounds.
// - Strobe edges resynchronised before stepping.
// - Strobe edges during calibration are dropped.
// - Direction low adds first, high second increment.
// - Automatic mode runs up to two segments.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module ramp_gen
  import ramp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        link_rst_b,
  input  wire logic        step_strobe_pin,
  input  wire logic        step_direction_pin,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [NUM_W-1:0] frac_num,
  output logic             cal_req
);

  // ****************************************************************
  // Strobe crossing.
  // ****************************************************************
  // Strobe edges are caught in the link domain and cross as a toggle, which
  // survives any phase between the two clocks at the cost of a few cycles.
  strobe_if sif ();

  strobe_sync u_sync (
    .link_clk   (link_clk),
    .link_rst_b (link_rst_b),
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .strobe_in  (step_strobe_pin),
    .dir_in     (step_direction_pin),
    .out        (sif.src)
  );

  // ****************************************************************
  // Register file.
  // ****************************************************************
  // Wide values are split into a low word and a two-bit high word. The halves
  // are written separately, so software must not update one while the
  // sequencer is using it.
  logic [4:0]       ctrl_reg;
  logic [INC_W-1:0] inc0_reg, inc1_reg;
  logic [LEN_W-1:0] len0_reg, len1_reg;
  logic [NUM_W-1:0] thresh_reg, low_reg, high_reg, base_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg, pslverr_reg;

  wire ctrl_active = ctrl_reg[CTRL_ACTIVE_BIT];
  wire ctrl_pin    = ctrl_reg[CTRL_PIN_BIT];
  wire ctrl_calseg = ctrl_reg[CTRL_CALSEG_BIT];
  wire access      = psel && penable && !pready_reg;
  wire commit      = psel && penable && pready_reg;
  wire wr          = commit && pwrite;
  wire hit_ctrl    = paddr == CTRL_OFF;
  wire hit_inc0    = paddr == INC0_OFF;
  wire hit_inc1    = paddr == INC1_OFF;
  wire hit_len0    = paddr == LEN0_OFF;
  wire hit_len1    = paddr == LEN1_OFF;
  wire hit_thl     = paddr == THRESH_LO_OFF;
  wire hit_thh     = paddr == THRESH_HI_OFF;
  wire hit_lol     = paddr == LOW_LO_OFF;
  wire hit_loh     = paddr == LOW_HI_OFF;
  wire hit_hil     = paddr == HIGH_LO_OFF;
  wire hit_hih     = paddr == HIGH_HI_OFF;
  wire hit_nul     = paddr == NUM_LO_OFF;
  wire hit_nuh     = paddr == NUM_HI_OFF;
  wire hit_st      = paddr == STATUS_OFF;
  wire mapped      = hit_ctrl | hit_inc0 | hit_inc1 | hit_len0 | hit_len1 | hit_thl | hit_thh
                   | hit_lol | hit_loh | hit_hil | hit_hih | hit_nul | hit_nuh | hit_st;
  wire start_wr    = wr && hit_ctrl && pwdata[CTRL_START_BIT];

  // A start write usually sets enable and per-segment calibration as well, so
  // both are taken from the written word; the stored copy is one cycle late.
  wire start_auto  = start_wr && pwdata[CTRL_ACTIVE_BIT] && !pwdata[CTRL_PIN_BIT];
  wire calseg_eff  = (wr && hit_ctrl) ? pwdata[CTRL_CALSEG_BIT] : ctrl_calseg;

  ramp_state_t state_reg, state_next;
  logic [7:0]  cal_cnt_reg;
  wire         calibrating = cal_cnt_reg != 8'h00;

  // Read mux: status shows state, calibration and pin direction.
  logic [31:0] rd_word;
  assign rd_word = hit_ctrl ? {27'h0, calibrating, ctrl_reg[3:0] & 4'h7}
                 : hit_inc0 ? {2'h0, inc0_reg}
                 : hit_inc1 ? {2'h0, inc1_reg}
                 : hit_len0 ? {16'h0, len0_reg}
                 : hit_len1 ? {16'h0, len1_reg}
                 : hit_thl  ? thresh_reg[31:0]
                 : hit_thh  ? {30'h0, thresh_reg[33:32]}
                 : hit_lol  ? low_reg[31:0]
                 : hit_loh  ? {30'h0, low_reg[33:32]}
                 : hit_hil  ? high_reg[31:0]
                 : hit_hih  ? {30'h0, high_reg[33:32]}
                 : hit_nul  ? frac_num[31:0]
                 : hit_nuh  ? {30'h0, frac_num[33:32]}
                 : hit_st   ? {26'h0, sif.step_dir, calibrating, state_reg}
                 : 32'h0;

  // One wait state per access keeps decode registered.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= RESET_WORD;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg  <= (access && !pwrite) ? rd_word : RESET_WORD;
    end
  end

  // Writes land at the edge that completes the transfer, with pready high.
  // Committing there keeps a stalled access from changing any state early.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_reg   <= 5'h00;
      inc0_reg   <= '0;
      inc1_reg   <= '0;
      len0_reg   <= '0;
      len1_reg   <= '0;
      thresh_reg <= '0;
      low_reg    <= LOW_RESET;
      high_reg   <= HIGH_RESET;
    end else if (wr) begin
      if (hit_ctrl) ctrl_reg <= {2'b00, pwdata[2:0]};
      if (hit_inc0) inc0_reg <= pwdata[INC_W-1:0];
      if (hit_inc1) inc1_reg <= pwdata[INC_W-1:0];
      if (hit_len0) len0_reg <= pwdata[LEN_W-1:0];
      if (hit_len1) len1_reg <= pwdata[LEN_W-1:0];
      if (hit_thl)  thresh_reg[31:0] <= pwdata;
      if (hit_thh)  thresh_reg[33:32] <= pwdata[1:0];
      if (hit_lol)  low_reg[31:0] <= pwdata;
      if (hit_loh)  low_reg[33:32] <= pwdata[1:0];
      if (hit_hil)  high_reg[31:0] <= pwdata;
      if (hit_hih)  high_reg[33:32] <= pwdata[1:0];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************************************
  // Ramp sequencing.
  // ****************************************************************
  logic [LEN_W-1:0] len_cnt_reg;
  logic [NUM_W-1:0] num_reg;
  logic             cal_reg;

  wire auto_mode = ctrl_active && !ctrl_pin;
  wire man_step  = ctrl_active && ctrl_pin && sif.step_pulse && !calibrating;
  // The segment in hand picks its own length; a length of zero ends at once.
  wire [LEN_W-1:0] seg_len = (state_reg == ST_SEG1) ? len1_reg : len0_reg;
  wire seg_end   = len_cnt_reg == seg_len;
  wire in_seg    = state_reg == ST_SEG0 || state_reg == ST_SEG1;
  wire auto_step = auto_mode && in_seg && !calibrating && !seg_end;

  // Two segments then stop; a start write or a drop of enable resets it.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_auto) state_next = ST_SEG0;
      ST_SEG0: if (!calibrating && seg_end) state_next = ST_SEG1;
      ST_SEG1: if (!calibrating && seg_end) state_next = ST_DONE;
      ST_DONE: if (start_auto) state_next = ST_SEG0;
      default: state_next = ST_IDLE;
    endcase
    if (!auto_mode && !start_auto) state_next = ST_IDLE;
  end

  wire seg_start = state_next != state_reg && (state_next == ST_SEG0 || state_next == ST_SEG1);

  // Step selection sign-extends the thirty-bit increment.
  wire use_second = ctrl_pin ? sif.step_dir : (state_reg == ST_SEG1);
  wire [INC_W-1:0] inc_sel = use_second ? inc1_reg : inc0_reg;
  wire [NUM_W-1:0] inc_ext = {{(NUM_W-INC_W){inc_sel[INC_W-1]}}, inc_sel};
  wire [NUM_W-1:0] sum     = num_reg + inc_ext;
  wire do_step = auto_step || man_step;

  // Signed clamp against both bounds. A step that would overshoot lands
  // exactly on the bound, so a later reverse step starts from the limit.
  wire [NUM_W-1:0] clamped = ($signed(sum) < $signed(low_reg))  ? low_reg
                           : ($signed(sum) > $signed(high_reg)) ? high_reg
                           : sum;
  // Drift is taken from the clamped value, so a ramp pinned at a bound
  // stops forcing calibrations once the base has caught up with it.
  wire [NUM_W-1:0] drift   = clamped - base_reg;
  wire [NUM_W-1:0] drift_a = drift[NUM_W-1] ? (~drift + 34'h1) : drift;
  wire thresh_hit = do_step && thresh_reg != '0 && drift_a >= thresh_reg;
  wire cal_start  = thresh_hit || (calseg_eff && seg_start);

  // Numerator, base of last calibration, segment counter.
  // A numerator write wins over a step in the same cycle, and a calibration
  // forced while another runs simply reloads the hold counter.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      num_reg     <= '0;
      base_reg    <= '0;
      len_cnt_reg <= '0;
      cal_cnt_reg <= 8'h00;
      cal_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr && hit_nul) num_reg[31:0] <= pwdata;
      else if (wr && hit_nuh) num_reg[33:32] <= pwdata[1:0];
      else if (do_step) num_reg <= clamped;
      if (cal_start) base_reg <= do_step ? clamped : num_reg;
      if (seg_start) len_cnt_reg <= '0;
      else if (auto_step) len_cnt_reg <= len_cnt_reg + 16'h1;
      if (cal_start) cal_cnt_reg <= 8'(CAL_CYCLES);
      else if (calibrating) cal_cnt_reg <= cal_cnt_reg - 8'h1;
      cal_reg <= cal_start;
    end
  end

  assign frac_num = num_reg;
  assign cal_req  = cal_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Checks on the bus, the sequencer and the numerator, all on the system clock.

  idle_no_step_a: assert property (!ctrl_active |=> $stable(num_reg) || $past(wr))
    else $error("Numerator moved while ramping disabled.");
  cal_drop_a: assert property (calibrating && ctrl_pin && !wr |=> $stable(num_reg))
    else $error("Step taken during calibration.");
  clamp_hi_a: assert property ($past(do_step) && !$past(wr)
    |-> $signed(num_reg) <= $signed(high_reg))
    else $error("Numerator above upper bound.");
  clamp_lo_a: assert property ($past(do_step) && !$past(wr)
    |-> $signed(num_reg) >= $signed(low_reg))
    else $error("Numerator below lower bound.");
  seg_cal_a: assert property (calseg_eff && seg_start |=> cal_req)
    else $error("No calibration at segment start.");
  cal_hold_a: assert property ($rose(cal_req) |-> calibrating [*8])
    else $error("Calibration hold too short.");
  auto_len_a: assert property (state_reg == ST_SEG0 && auto_step
    |=> len_cnt_reg == $past(len_cnt_reg) + 16'h1)
    else $error("Segment counter did not advance.");
  two_seg_a: assert property (state_reg == ST_DONE && !start_auto
    |=> state_reg != ST_SEG0 && state_reg != ST_SEG1)
    else $error("More than two segments.");
  step_add_a: assert property (auto_step && !wr && clamped == sum
    |=> num_reg == $past(num_reg) + $past(inc_ext))
    else $error("Wrong increment applied.");
  seg0_len_a: assert property (state_reg == ST_SEG0 && state_next == ST_SEG1
    |-> len_cnt_reg == len0_reg)
    else $error("First segment ended at the wrong count.");
  seg1_len_a: assert property (state_reg == ST_SEG1 && state_next == ST_DONE
    |-> len_cnt_reg == len1_reg)
    else $error("Second segment ended at the wrong count.");
  off_idle_a: assert property (!ctrl_active && !start_auto |=> state_reg == ST_IDLE)
    else $error("Sequencer left idle while disabled.");
  thresh_cal_a: assert property (thresh_hit |=> cal_req && calibrating)
    else $error("Threshold crossing did not force a calibration.");
  man_lo_a: assert property (man_step && !sif.step_dir && !wr && clamped == sum
    |=> $signed(num_reg - $past(num_reg)) == $signed($past(inc0_reg)))
    else $error("Low direction did not add the first increment.");
  man_hi_a: assert property (man_step && sif.step_dir && !wr && clamped == sum
    |=> $signed(num_reg - $past(num_reg)) == $signed($past(inc1_reg)))
    else $error("High direction did not add the second increment.");
  resp_pulse_a: assert property (pready |=> !pready)
    else $error("Bus answer held longer than one cycle.");

  cov_auto_c: cover property (state_reg == ST_SEG1 ##1 state_reg == ST_DONE);
  cov_man_c:  cover property (man_step);
  cov_drop_c: cover property (sif.step_pulse && calibrating && ctrl_pin);
  cov_thr_c:  cover property (thresh_hit);
  cov_segcal_c: cover property (calseg_eff && seg_start);

endmodule // ramp_gen

// ===== dv/strobe_ctrl_model.sv
// Behavioural external controller that drives the step strobe and direction pins.
`timescale 1ns/1ns
module strobe_ctrl_model (
  output logic step_strobe_pin,
  output logic step_direction_pin
);
  // ****************************************************************
  // Pin driver
  // ****************************************************************

  // Both pins rest low until the first step is asked for.
  initial begin
    step_strobe_pin    = 1'b0;
    step_direction_pin = 1'b0;
  end

  // One whole strobe period takes 4000 ns, so the rate never exceeds 250 kHz.
  // The direction settles 1000 ns ahead of the rising edge, so the two pins
  // never change close together and the sampled direction is unambiguous.
  task automatic step(input logic up);
    step_direction_pin = up;
    #1000;
    step_strobe_pin = 1'b1;
    #2000;
    step_strobe_pin = 1'b0;
    #1000;
  endtask
endmodule // strobe_ctrl_model

// ===== dv/ramp_gen_tb.sv
// Self-checking testbench for the frequency ramp generator.
`timescale 1ns/1ns
module ramp_gen_tb
  import ramp_pkg::*;
;
  logic             sys_clk    = 1'b0;
  logic             link_clk   = 1'b1;
  logic             rst_b      = 1'b0;
  logic             link_rst_b = 1'b0;
  logic             psel       = 1'b0;
  logic             penable    = 1'b0;
  logic             pwrite     = 1'b0;
  logic [7:0]       paddr      = 8'h00;
  logic [31:0]      pwdata     = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [NUM_W-1:0] frac_num;
  logic             cal_req;
  wire logic        step_strobe_pin;
  wire logic        step_direction_pin;
  int               num_errors = 0;
  int               n_compared = 0;
  int               n_cal      = 0;
  logic [31:0]      q;
  logic             e;

  // The system clock stands for the phase detector at 100 MHz with no divide,
  // so it sits at the state clock and below the ramping ceiling. The link
  // clock period differs from the system one, so phases drift apart.
  always #5 sys_clk = ~sys_clk;
  always #6 link_clk = ~link_clk;

  // Every forced calibration pulse is counted here.
  always @(posedge sys_clk) if (cal_req === 1'b1) n_cal++;

  ramp_gen dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .link_rst_b(link_rst_b),
    .step_strobe_pin(step_strobe_pin), .step_direction_pin(step_direction_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frac_num(frac_num),
    .cal_req(cal_req)
  );

  strobe_ctrl_model ctrl_u (
    .step_strobe_pin(step_strobe_pin),
    .step_direction_pin(step_direction_pin)
  );

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int t;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) num_errors++;
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, a, 32'h0, rq, re);
    chk(nm, {32'h0, rq}, {32'h0, exp});
  endtask

  // Restarts from a zero numerator, then polls until the ramp reports done.
  task automatic run_auto(input logic [31:0] ctrl, input logic [33:0] num, input int cals,
                          input string nm);
    logic [31:0] rq;
    logic        re;
    int          t;
    wr(CTRL_OFF, 32'h0);
    wr(NUM_LO_OFF, 32'h0);
    wr(NUM_HI_OFF, 32'h0);
    n_cal = 0;
    wr(CTRL_OFF, ctrl);
    t = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0, rq, re);
      t++;
    end while (rq[3:0] !== 4'h8 && t < 100);
    if (t >= 100) num_errors++;
    chk({nm, "_num"}, {30'h0, frac_num}, {30'h0, num});
    chk({nm, "_cal"}, 64'(n_cal), 64'(cals));
    $display("test %s done", nm);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************

  // A hang of the bench or design is cut short well after the tests' span.
  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b      <= 1'b1;
    link_rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("num_rst", {30'h0, frac_num}, 64'h0);
    rd(HIGH_LO_OFF, 32'hffff_ffff, "high_lo");
    rd(HIGH_HI_OFF, 32'h1, "high_hi");
    rd(LOW_HI_OFF, 32'h2, "low_hi");
    rd(STATUS_OFF, 32'h1, "status_rst");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped", {31'h0, e, q}, {31'h0, 1'b1, 32'h0});
    $display("test reset done");
    // Increments are in units of the fixed ramp denominator; denominator and
    // lock-detect delay live outside this block and are taken as set.
    // A negative second increment checks the two's complement reading.
    wr(INC0_OFF, 32'h5);
    wr(INC1_OFF, 32'h3fff_fffd);
    wr(LEN0_OFF, 32'h4);
    wr(LEN1_OFF, 32'h3);
    wr(CTRL_OFF, 32'h8);
    repeat (20) @(posedge sys_clk);
    chk("inactive_num", {30'h0, frac_num}, 64'h0);
    rd(STATUS_OFF, 32'h1, "inactive_st");
    run_auto(32'h9, 34'd11, 0, "auto");
    wr(THRESH_LO_OFF, 32'h8);
    run_auto(32'h9, 34'd11, 3, "thresh");
    wr(THRESH_LO_OFF, 32'h0);
    run_auto(32'hd, 34'd11, 2, "segcal");
    wr(HIGH_LO_OFF, 32'ha);
    wr(HIGH_HI_OFF, 32'h0);
    wr(LOW_LO_OFF, 32'h3);
    wr(LOW_HI_OFF, 32'h0);
    run_auto(32'h9, 34'd3, 0, "clamp");
    // Manual steps stay inside the narrowed bounds on purpose.
    wr(CTRL_OFF, 32'h0);
    wr(NUM_LO_OFF, 32'h3);
    wr(NUM_HI_OFF, 32'h0);
    // The last calibration base is 20, so the step to 8 moves by 12 and
    // recalibrates; the step back to 5 moves by 3 and does not.
    wr(THRESH_LO_OFF, 32'h4);
    n_cal = 0;
    wr(CTRL_OFF, 32'h3);
    rd(CTRL_OFF, 32'h3, "ctrl_rb");
    ctrl_u.step(1'b0);
    chk("man_lo", {30'h0, frac_num}, 64'd8);
    ctrl_u.step(1'b1);
    chk("man_hi", {30'h0, frac_num}, 64'd5);
    wr(CTRL_OFF, 32'h2);
    ctrl_u.step(1'b0);
    chk("man_off", {30'h0, frac_num}, 64'd5);
    chk("man_cal", 64'(n_cal), 64'd1);
    $display("test manual done");
    close_out();
  end
endmodule // ramp_gen_tb
